// ---- hw/sea_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module sea_top #(
  parameter int unsigned PROG_CYCLES = sea_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oen,
  input wire logic wp_in,
  input wire logic [2:0] chip_select_pins,
  output logic busy
);
  import sea_pkg::*;

  typedef struct packed {
    sea_state_t st;
    sea_state_t after;
    logic scl_q;
    logic sda_q;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rack;
    logic [ADDR_W-1:0] addr;
    logic prog;
    logic [TIMER_W-1:0] timer;
    logic wp_lock;
    logic wrote;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0] pval;
    logic [ADDR_W-PAGE_W-1:0] ppage;
    logic oen;
    logic dout;
  } sea_core_t;

  sea_core_t s_reg;
  sea_core_t s_next;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_done;
  logic commit;

  sea_pins_if pins ();

  //------------------------------------------------------------
  // Pin synchronisation
  //------------------------------------------------------------
  sea_pin_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .raw({chip_select_pins, wp_in, sda_in, scl_in}),
    .pins(pins)
  );

  // Bus events from filtered levels
  assign scl_rise = pins.scl & ~s_reg.scl_q;
  assign scl_fall = ~pins.scl & s_reg.scl_q;
  assign start_ev = pins.scl & s_reg.scl_q & s_reg.sda_q & ~pins.sda;
  assign stop_ev = pins.scl & s_reg.scl_q & ~s_reg.sda_q & pins.sda;
  assign byte_done = scl_fall && (s_reg.cnt == BITS_PER_BYTE);
  assign rd_byte = mem[s_reg.addr];
  assign commit = s_reg.prog && (s_reg.timer == '0);

  //------------------------------------------------------------
  // Protocol engine
  //------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.scl_q = pins.scl;
    s_next.sda_q = pins.sda;
    if (s_reg.prog) begin
      // Deaf and silent while programming
      s_next.st = SEA_IDLE;
      s_next.oen = 1'b1;
      if (commit) begin
        s_next.prog = 1'b0;
        s_next.pval = '0;
        s_next.wrote = 1'b0;
      end else begin
        s_next.timer = s_reg.timer - 1'b1;
      end
    end else if (start_ev) begin
      s_next.st = SEA_DEV;
      s_next.cnt = '0;
      s_next.oen = 1'b1;
      s_next.wrote = 1'b0;
      s_next.pval = '0;
    end else if (stop_ev) begin
      s_next.st = SEA_IDLE;
      s_next.oen = 1'b1;
      if (s_reg.wrote) begin
        s_next.prog = 1'b1;
        s_next.timer = TIMER_W'(PROG_CYCLES - 1);
        s_next.wp_lock = pins.wp;
      end
    end else begin
      case (s_reg.st)
        SEA_DEV, SEA_ADDR_HI, SEA_ADDR_LO, SEA_WDATA: begin
          if (scl_rise) begin
            s_next.sh = {s_reg.sh[6:0], pins.sda};
            s_next.cnt = s_reg.cnt + 1'b1;
          end else if (byte_done) begin
            s_next.oen = 1'b0;
            s_next.st = SEA_ACK;
            case (s_reg.st)
              SEA_DEV: begin
                if (s_reg.sh[7:4] == DEV_TYPE && s_reg.sh[3:1] == pins.cs) begin
                  s_next.after = s_reg.sh[0] ? SEA_RDATA : SEA_ADDR_HI;
                end else begin
                  s_next.oen = 1'b1;
                  s_next.st = SEA_IDLE;
                end
              end
              SEA_ADDR_HI: begin
                s_next.addr[ADDR_W-1:8] = s_reg.sh[ADDR_W-9:0];
                s_next.after = SEA_ADDR_LO;
              end
              SEA_ADDR_LO: begin
                s_next.addr[7:0] = s_reg.sh;
                s_next.after = SEA_WDATA;
              end
              default: begin
                // Latch into page buffer, later bytes replace earlier
                s_next.pbuf[s_reg.addr[PAGE_W-1:0]] = s_reg.sh;
                s_next.pval[s_reg.addr[PAGE_W-1:0]] = 1'b1;
                s_next.ppage = s_reg.addr[ADDR_W-1:PAGE_W];
                s_next.addr[PAGE_W-1:0] = s_reg.addr[PAGE_W-1:0] + 1'b1;
                s_next.wrote = 1'b1;
                s_next.after = SEA_WDATA;
              end
            endcase
          end
        end
        SEA_ACK: begin
          if (scl_fall) begin
            s_next.cnt = '0;
            s_next.oen = 1'b1;
            s_next.st = s_reg.after;
            if (s_reg.after == SEA_RDATA) begin
              s_next.oen = rd_byte[7];
              s_next.sh = {rd_byte[6:0], 1'b0};
              s_next.cnt = 4'h1;
            end
          end
        end
        SEA_RDATA: begin
          if (scl_fall) begin
            if (s_reg.cnt == BITS_PER_BYTE) begin
              s_next.oen = 1'b1;
              s_next.addr = s_reg.addr + 1'b1;
              s_next.st = SEA_RACK;
            end else begin
              s_next.oen = s_reg.sh[7];
              s_next.sh = {s_reg.sh[6:0], 1'b0};
              s_next.cnt = s_reg.cnt + 1'b1;
            end
          end
        end
        SEA_RACK: begin
          if (scl_rise) begin
            s_next.rack = ~pins.sda;
            if (pins.sda) begin
              s_next.st = SEA_IDLE;
            end
          end else if (scl_fall && s_reg.rack) begin
            s_next.rack = 1'b0;
            s_next.oen = rd_byte[7];
            s_next.sh = {rd_byte[6:0], 1'b0};
            s_next.cnt = 4'h1;
            s_next.st = SEA_RDATA;
          end
        end
        default: begin
          s_next.st = SEA_IDLE;
          s_next.oen = 1'b1;
        end
      endcase
    end
  end

  // Core state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '{st: SEA_IDLE, after: SEA_IDLE, scl_q: 1'b1, sda_q: 1'b1, sh: 8'h00,
                 cnt: 4'h0, rack: 1'b0, addr: ADDR_RST, prog: 1'b0, timer: '0,
                 wp_lock: 1'b0, wrote: 1'b0, pbuf: '0, pval: '0, ppage: '0,
                 oen: 1'b1, dout: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  //------------------------------------------------------------
  // Array commit at end of programming
  //------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (commit) begin
      for (int k = 0; k < PAGE_BYTES; k++) begin
        if (s_reg.pval[k] && !(s_reg.wp_lock && s_reg.ppage[7:6] == PROT_QUARTER)) begin
          mem[{s_reg.ppage, PAGE_W'(k)}] <= s_reg.pbuf[k];
        end
      end
    end
  end

  assign sda_oen = s_reg.oen;
  assign sda_out = s_reg.dout;
  assign busy = s_reg.prog;
endmodule : sea_top
`default_nettype wire

// ---- include/sea_pkg.sv ----
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
package sea_pkg;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int PAGE_BYTES = 32;
  localparam int MEM_BYTES = 8192;
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [1:0] PROT_QUARTER = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int PROG_TIME_US = 5000;
  localparam int CLK_MHZ = 250;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 21;
  localparam int SYNC_W = 6;
  typedef enum logic [3:0] {
    SEA_IDLE, SEA_DEV, SEA_ADDR_HI, SEA_ADDR_LO, SEA_WDATA, SEA_ACK, SEA_RDATA, SEA_RACK
  } sea_state_t;
endpackage : sea_pkg

// ---- include/sea_pins_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Filtered pin levels from synchroniser to protocol engine
interface sea_pins_if;
  logic scl;
  logic sda;
  logic wp;
  logic [2:0] cs;
  modport src (output scl, output sda, output wp, output cs);
  modport dst (input scl, input sda, input wp, input cs);
endinterface : sea_pins_if
`default_nettype wire

// ---- hw/sea_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module sea_pin_sync #(
  parameter int W = sea_pkg::SYNC_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] raw,
  sea_pins_if.src pins
);
  import sea_pkg::*;

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] stable;
  } sea_sync_t;

  sea_sync_t s_reg;
  sea_sync_t s_next;
  logic [W-1:0] agree;

  //------------------------------------------------------------
  // Agreement of second and third stage
  //------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_agree
      assign agree[i] = ~(s_reg.ff2[i] ^ s_reg.ff3[i]);
    end
  endgenerate

  // Shift chain, stable level follows on agreement
  always_comb begin
    s_next = s_reg;
    s_next.ff1 = raw;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    s_next.stable = (agree & s_reg.ff3) | (~agree & s_reg.stable);
  end

  // Idle bus levels high, selects low
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '{ff1: 6'h07, ff2: 6'h07, ff3: 6'h07, stable: 6'h07};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins.scl = s_reg.stable[0];
  assign pins.sda = s_reg.stable[1];
  assign pins.wp = s_reg.stable[2];
  assign pins.cs = s_reg.stable[5:3];
endmodule : sea_pin_sync
`default_nettype wire

// ---- test/sea_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module sea_asserts #(
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oen,
  input wire logic wp_in,
  input wire logic [2:0] chip_select_pins,
  input wire logic busy
);
  logic sda_d_reg;
  logic [3:0] stop_age_reg;
  logic [31:0] busy_cnt_reg;
  logic stop_w;
  logic start_w;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Pin-level start, stop and busy length
  // ----------------------------------------
  assign stop_w = scl_in && sda_in && !sda_d_reg;
  assign start_w = scl_in && !sda_in && sda_d_reg;
  always_ff @(posedge clk) begin
    sda_d_reg <= sda_in;
    busy_cnt_reg <= busy ? busy_cnt_reg + 32'h1 : 32'h0;
    if (!rstn || stop_w) begin
      stop_age_reg <= rstn ? 4'h0 : 4'hf;
    end else if (stop_age_reg != 4'hf) begin
      stop_age_reg <= stop_age_reg + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_drive_zero: assert property (sda_out == 1'h0) else $error("drive not low");
  a_busy_quiet: assert property (busy |-> sda_oen) else $error("drive while busy");
  a_ack_on_low: assert property ($changed(sda_oen) |-> !scl_in)
    else $error("drive change with clock high");
  a_prog_start: assert property ($rose(busy) |-> stop_age_reg < 4'ha)
    else $error("busy without stop");
  a_prog_hold: assert property ($rose(busy) |=> busy [*8]) else $error("busy dropped");
  a_prog_bound: assert property (busy_cnt_reg <= PROG_CYCLES + 1)
    else $error("busy too long");
  a_stop_free: assert property (stop_w |-> sda_oen) else $error("drive at stop");
  a_start_free: assert property (start_w |-> sda_oen) else $error("drive at start");
  c_prog: cover property ($rose(busy));
  c_ack: cover property (!sda_oen);
  c_done: cover property ($fell(busy));
endmodule : sea_asserts
bind sea_top sea_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.clk(clk), .rstn(rstn),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oen(sda_oen), .wp_in(wp_in),
  .chip_select_pins(chip_select_pins), .busy(busy));
`default_nettype wire

// ---- test/sea_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Bus controller: open drain, 1 releases the line
module sea_ctrl_model (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  // Half of the 80 ns bus clock
  task automatic hp();
    repeat (10) @(posedge clk);
  endtask : hp
  // Data moves only well after the clock fell
  task automatic lo(input logic v);
    repeat (3) @(posedge clk);
    sda <= v;
    // Rest of the low phase, so low plus high make 80 ns
    repeat (7) @(posedge clk);
  endtask : lo
  // Start or repeated start
  task automatic start();
    lo(1'h1);
    scl <= 1'h1;
    hp();
    sda <= 1'h0;
    hp();
    scl <= 1'h0;
  endtask : start
  // Stop; the clock then stands high
  task automatic stop();
    lo(1'h0);
    scl <= 1'h1;
    hp();
    sda <= 1'h1;
    hp();
  endtask : stop
  // One byte MSB first, then the acknowledge bit
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 8; i >= 0; i--) begin
      lo(i > 0 ? d[i-1] : a);
      scl <= 1'h1;
      hp();
      if (i > 0) q[i-1] = sda_w;
      else k = sda_w;
      scl <= 1'h0;
    end
  endtask : xbyte
endmodule : sea_ctrl_model
`default_nettype wire

// ---- test/tb_sea_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_sea_top;
  import sea_pkg::*;
  localparam int unsigned PCYC = 2000;
  localparam logic [2:0] CS = 3'h5;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic wp = 1'h0;
  logic scl, sda, sda_out, sda_oen, busy, sda_w, k;
  logic [7:0] q;
  int err_count = 0;
  int compares = 0;
  assign sda_w = sda & (sda_oen | sda_out);
  always #2 clk = ~clk;
  sea_top #(.PROG_CYCLES(PCYC)) u_dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oen(sda_oen), .wp_in(wp), .chip_select_pins(CS), .busy(busy));
  sea_ctrl_model u_ctrl (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("Mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // Send a byte, judge the acknowledge
  task automatic tx(input logic [7:0] d, input logic ack);
    u_ctrl.xbyte(d, 1'h1, q, k);
    check({7'h0, k}, {7'h0, ack});
  endtask : tx
  task automatic rx(input logic more, input logic [7:0] exp);
    u_ctrl.xbyte(8'hff, !more, q, k);
    check(q, exp);
  endtask : rx
  task automatic addr(input logic [12:0] a);
    u_ctrl.start();
    tx({DEV_TYPE, CS, 1'h0}, 1'h0);
    tx({3'h7, a[12:8]}, 1'h0);
    tx(a[7:0], 1'h0);
  endtask : addr
  task automatic rd(input logic [12:0] a);
    addr(a);
    u_ctrl.start();
    tx({DEV_TYPE, CS, 1'h1}, 1'h0);
  endtask : rd
  task automatic idle();
    int n;
    for (n = 0; n < 3000 && busy !== 1'h0; n++) @(posedge clk);
    check({7'h0, busy}, 8'h00);
    if (n == 3000) summarize();
  endtask : idle
  // Stop, poll while busy, poll again when done
  task automatic prog();
    u_ctrl.stop();
    repeat (12) @(posedge clk);
    check({7'h0, busy}, 8'h01);
    u_ctrl.start();
    tx({DEV_TYPE, CS, 1'h0}, 1'h1);
    idle();
    u_ctrl.start();
    tx({DEV_TYPE, CS, 1'h0}, 1'h0);
    u_ctrl.stop();
  endtask : prog
  // Byte landed at page offset o by the 34-byte write
  function automatic logic [7:0] exp_pg(input int o);
    int i;
    i = (o + 2) % 32;
    if (i < 2) i += 32;
    return 8'h40 + i[7:0];
  endfunction : exp_pg
  task automatic t_miss();
    u_ctrl.start();
    tx({DEV_TYPE, ~CS, 1'h1}, 1'h1);
    u_ctrl.start();
    tx({4'h5, CS, 1'h1}, 1'h1);
    u_ctrl.stop();
  endtask : t_miss
  task automatic t_page();
    addr(13'h0ffe);
    for (int i = 0; i < 34; i++) tx(8'h40 + i[7:0], 1'h0);
    prog();
  endtask : t_page
  task automatic t_seq();
    rd(13'h0fe0);
    for (int o = 0; o < 31; o++) rx(o < 30, exp_pg(o));
    u_ctrl.stop();
    u_ctrl.start();
    tx({DEV_TYPE, CS, 1'h1}, 1'h0);
    rx(1'h0, exp_pg(31));
    u_ctrl.stop();
  endtask : t_seq
  task automatic t_top();
    addr(13'h1fff);
    tx(8'h5a, 1'h0);
    prog();
    addr(13'h0000);
    tx(8'ha5, 1'h0);
    prog();
    wp <= 1'h1;
    addr(13'h1fff);
    tx(8'h00, 1'h0);
    u_ctrl.stop();
    repeat (12) @(posedge clk);
    idle();
    wp <= 1'h0;
    rd(13'h1fff);
    rx(1'h1, 8'h5a);
    rx(1'h0, 8'ha5);
    u_ctrl.stop();
  endtask : t_top
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (8) @(posedge clk);
    t_miss();
    t_page();
    t_seq();
    t_top();
    summarize();
  end
endmodule : tb_sea_top
`default_nettype wire
